//--- hw/ees_map.svh
`ifndef EES_MAP_SVH
`define EES_MAP_SVH

// Array geometry
`define EES_WORDS 256
`define EES_LAST_ADDR 8'hFF

// Clock pulses expected per instruction
`define EES_CNT_SHORT 6'd11
`define EES_CNT_LONG 6'd27
`define EES_CNT_MAX 6'h3F
`define EES_CNT_START 6'd1
`define EES_SR_FULL 6'd26

// Opcode field values
`define EES_OP_MISC 2'h0
`define EES_OP_WRITE 2'h1
`define EES_OP_READ 2'h2
`define EES_OP_CLEAR 2'h3

// Address-field selectors of the miscellaneous and clear opcodes
`define EES_SEL_LOCK 2'h0
`define EES_SEL_FILL 2'h1
`define EES_SEL_UNLOCK 2'h3
`define EES_ADDR_FREEZE 8'h00
`define EES_ADDR_CLEAR 8'hFF

// Boundary register reset contents
`define EES_BOUND_RST 8'hFF
`define EES_FLAG_RST 1'b1
`define EES_FLAG_CLEARED 1'b1
`define EES_FLAG_ACTIVE 1'b0

// Guard query frame: dummy bit, boundary, flag
`define EES_QRY_LEN 10
`define EES_QRY_DUMMY 1'b0

// Self-timed programming time
`define EES_PROG_TIME_US 100
`define EES_CLK_PERIOD_NS 10

`endif

//--- hw/ees_pkg.sv
package ees_pkg;

    // Serial front-end states, Gray coded
    typedef enum logic [1:0] {
        EES_ST_IDLE  = 2'h0,
        EES_ST_SHIFT = 2'h1,
        EES_ST_BUSY  = 2'h3
    } ees_state_t;

    // Instructions decoded at the end of a frame
    typedef enum logic [3:0] {
        EES_K_NONE   = 4'h0,
        EES_K_WRITE  = 4'h1,
        EES_K_FILL   = 4'h2,
        EES_K_UNLOCK = 4'h3,
        EES_K_LOCK   = 4'h4,
        EES_K_GUNLK  = 4'h5,
        EES_K_GSET   = 4'h6,
        EES_K_GRESET = 4'h7,
        EES_K_GFRZ   = 4'h8
    } ees_kind_t;

endpackage

//--- hw/ees_prog_timer.sv
`timescale 1ns/1ns
module ees_prog_timer #(
    parameter int CYCLES = 10000
) (
    input wire logic clk_i,    // System clock
    input wire logic rst_n_i,  // Async reset, active low
    input wire logic start_i,  // Start a programming cycle
    output logic busy_o,       // Cycle in progress
    output logic done_o        // One-cycle end pulse
);

    logic [31:0] cnt_reg;

    // Count runs only while busy, on the system clock, independent of the serial clock
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg <= 32'h0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i && !busy_o) begin
                busy_o <= 1'b1;
                cnt_reg <= 32'h0;
            end else if (busy_o) begin
                if (cnt_reg == 32'(CYCLES - 1)) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg + 32'h1;
                end
            end
        end
    end

endmodule

//--- hw/ees_core.sv
`timescale 1ns/1ns
`include "ees_map.svh"
module ees_core #(
    parameter int PROG_CYCLES = `EES_PROG_TIME_US * 1000 / `EES_CLK_PERIOD_NS
) (
    input wire logic clk_i,                 // System clock, 100 MHz
    input wire logic rst_n_i,               // Async reset, active low
    input wire logic device_pick_i,         // Chip select
    input wire logic shift_timing_i,        // Serial clock
    input wire logic input_bit_line_i,      // Serial data in
    input wire logic program_permit_i,      // Write permission pin
    input wire logic guard_access_i,        // Boundary register access pin
    input wire logic [7:0] peek_addr_i,     // Array inspection address
    output logic output_bit_line_o,         // Serial data out
    output logic output_bit_line_oe_o,      // Serial data out enable
    output logic [15:0] peek_data_o         // Array inspection data
);

    // ----------------------------------------
    // Edge detection and state
    // ----------------------------------------
    ees_pkg::ees_state_t state_reg;
    ees_pkg::ees_kind_t kind;
    logic clk_prev_reg;
    logic c_rise;
    logic [5:0] cnt_reg;
    logic [25:0] sr_reg;
    logic pre_frame_reg;
    logic pre_ok_reg;
    logic w_ok_reg;
    logic prog_en_reg;
    logic guard_en_reg;
    logic [7:0] boundary_reg;
    logic flag_reg;
    logic freeze_reg;
    logic ready_hold_reg;
    logic qry_active_reg;
    logic [9:0] qry_sr_reg;
    logic [15:0] mem [`EES_WORDS];
    logic decide;
    logic start_bit;
    logic is_long;
    logic is_short;
    logic [1:0] op_l;
    logic [1:0] op_s;
    logic [7:0] addr_l;
    logic [7:0] addr_s;
    logic [15:0] data_l;
    logic protected_hit;
    logic guard_ok;
    logic start_prog;
    logic tmr_busy;
    logic tmr_done;
    logic [31:0] busy_cyc_reg;

    // Serial clock edge against previous sample
    assign c_rise = shift_timing_i && !clk_prev_reg;
    // Start bit while selected and idle
    assign start_bit = (state_reg == ees_pkg::EES_ST_IDLE) && device_pick_i && c_rise && input_bit_line_i;
    assign decide = (state_reg == ees_pkg::EES_ST_SHIFT) && !device_pick_i;

    // Previous serial clock level
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clk_prev_reg <= 1'b0;
        end else begin
            clk_prev_reg <= shift_timing_i;
        end
    end

    // ----------------------------------------
    // Frame fields
    // ----------------------------------------
    // 27 or 11 pulse frames
    assign is_long = (cnt_reg == `EES_CNT_LONG);
    assign is_short = (cnt_reg == `EES_CNT_SHORT);
    assign op_l = sr_reg[25:24];
    assign addr_l = sr_reg[23:16];
    assign data_l = sr_reg[15:0];
    assign op_s = sr_reg[9:8];
    assign addr_s = sr_reg[7:0];

    // ----------------------------------------
    // Front-end sequencer
    // ----------------------------------------
    // Busy state ignores input
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= ees_pkg::EES_ST_IDLE;
        end else begin
            case (state_reg)
                ees_pkg::EES_ST_IDLE: begin
                    if (start_bit) begin
                        state_reg <= ees_pkg::EES_ST_SHIFT;
                    end
                end
                ees_pkg::EES_ST_SHIFT: begin
                    if (decide) begin
                        state_reg <= start_prog ? ees_pkg::EES_ST_BUSY : ees_pkg::EES_ST_IDLE;
                    end
                end
                ees_pkg::EES_ST_BUSY: begin
                    if (tmr_done) begin
                        state_reg <= ees_pkg::EES_ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ees_pkg::EES_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg <= 6'h0;
        end else if (start_bit) begin
            cnt_reg <= `EES_CNT_START;
        end else if (state_reg == ees_pkg::EES_ST_SHIFT && device_pick_i && c_rise && cnt_reg != `EES_CNT_MAX) begin
            cnt_reg <= cnt_reg + 6'h1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sr_reg <= 26'h0;
        end else if (start_bit) begin
            sr_reg <= 26'h0;
        end else if (state_reg == ees_pkg::EES_ST_SHIFT && device_pick_i && c_rise && cnt_reg <= `EES_SR_FULL) begin
            sr_reg <= {sr_reg[24:0], input_bit_line_i};
        end
    end

    // Pin levels held over whole frame
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pre_frame_reg <= 1'b0;
            pre_ok_reg <= 1'b0;
            w_ok_reg <= 1'b0;
        end else if (start_bit) begin
            pre_frame_reg <= guard_access_i;
            pre_ok_reg <= guard_access_i;
            w_ok_reg <= program_permit_i;
        end else if (state_reg == ees_pkg::EES_ST_SHIFT) begin
            pre_ok_reg <= pre_ok_reg && guard_access_i;
            w_ok_reg <= w_ok_reg && program_permit_i;
        end
    end

    // ----------------------------------------
    // Instruction decode
    // ----------------------------------------
    // Opcode space chosen by guard access at start
    always_comb begin
        kind = ees_pkg::EES_K_NONE;
        if (!pre_frame_reg) begin
            if (is_long && op_l == `EES_OP_WRITE) begin
                kind = ees_pkg::EES_K_WRITE;
            end else if (is_long && op_l == `EES_OP_MISC && addr_l[7:6] == `EES_SEL_FILL) begin
                kind = ees_pkg::EES_K_FILL;
            end else if (is_short && op_s == `EES_OP_MISC && addr_s[7:6] == `EES_SEL_UNLOCK) begin
                kind = ees_pkg::EES_K_UNLOCK;
            end else if (is_short && op_s == `EES_OP_MISC && addr_s[7:6] == `EES_SEL_LOCK) begin
                kind = ees_pkg::EES_K_LOCK;
            end
        end else if (is_short) begin
            if (op_s == `EES_OP_WRITE) begin
                kind = ees_pkg::EES_K_GSET;
            end else if (op_s == `EES_OP_CLEAR && addr_s == `EES_ADDR_CLEAR) begin
                kind = ees_pkg::EES_K_GRESET;
            end else if (op_s == `EES_OP_MISC && addr_s[7:6] == `EES_SEL_UNLOCK) begin
                kind = ees_pkg::EES_K_GUNLK;
            end else if (op_s == `EES_OP_MISC && addr_s == `EES_ADDR_FREEZE) begin
                kind = ees_pkg::EES_K_GFRZ;
            end
        end
    end

    assign protected_hit = (flag_reg == `EES_FLAG_ACTIVE) && (addr_l >= boundary_reg);
    // Frozen or not unlocked blocks guard writes
    assign guard_ok = guard_en_reg && w_ok_reg && pre_ok_reg && !freeze_reg;

    always_comb begin
        start_prog = 1'b0;
        if (decide) begin
            case (kind)
                ees_pkg::EES_K_WRITE: start_prog = prog_en_reg && w_ok_reg && !protected_hit;
                ees_pkg::EES_K_FILL: start_prog = prog_en_reg && w_ok_reg && flag_reg == `EES_FLAG_CLEARED;
                ees_pkg::EES_K_GSET: start_prog = guard_ok;
                ees_pkg::EES_K_GRESET: start_prog = guard_ok;
                ees_pkg::EES_K_GFRZ: start_prog = guard_ok;
                default: start_prog = 1'b0;
            endcase
        end
    end

    // ----------------------------------------
    // Permission state
    // ----------------------------------------
    // Locked from reset
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prog_en_reg <= 1'b0;
        end else if (decide && kind == ees_pkg::EES_K_UNLOCK && w_ok_reg) begin
            prog_en_reg <= 1'b1;
        end else if (decide && kind == ees_pkg::EES_K_LOCK) begin
            prog_en_reg <= 1'b0;
        end
    end

    // Guard unlock armed for next frame only
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            guard_en_reg <= 1'b0;
        end else if (decide) begin
            guard_en_reg <= (kind == ees_pkg::EES_K_GUNLK) && prog_en_reg && w_ok_reg && pre_ok_reg;
        end
    end

    // ----------------------------------------
    // Boundary register
    // ----------------------------------------
    // Only set and reset touch the flag
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            boundary_reg <= `EES_BOUND_RST;
            flag_reg <= `EES_FLAG_RST;
        end else if (start_prog && kind == ees_pkg::EES_K_GRESET) begin
            boundary_reg <= `EES_ADDR_CLEAR;
            flag_reg <= `EES_FLAG_CLEARED;
        end else if (start_prog && kind == ees_pkg::EES_K_GSET) begin
            boundary_reg <= addr_s;
            flag_reg <= `EES_FLAG_ACTIVE;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            freeze_reg <= 1'b0;
        end else if (start_prog && kind == ees_pkg::EES_K_GFRZ) begin
            freeze_reg <= 1'b1;
        end
    end

    // ----------------------------------------
    // Array and programming timer
    // ----------------------------------------
    // Fill writes every word at once
    always_ff @(posedge clk_i) begin
        if (start_prog && kind == ees_pkg::EES_K_FILL) begin
            for (int i = 0; i < `EES_WORDS; i++) begin
                mem[i] <= data_l;
            end
        end else if (start_prog && kind == ees_pkg::EES_K_WRITE) begin
            mem[addr_l] <= data_l;
        end
    end

    // Registered inspection read
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            peek_data_o <= 16'h0;
        end else begin
            peek_data_o <= mem[peek_addr_i];
        end
    end

    // Cycle timed on the system clock
    ees_prog_timer #(
        .CYCLES(PROG_CYCLES)
    ) u_timer (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .start_i(start_prog),
        .busy_o(tmr_busy),
        .done_o(tmr_done)
    );

    // ----------------------------------------
    // Serial output
    // ----------------------------------------
    // Ready held; end of cycle wins over clear
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ready_hold_reg <= 1'b0;
        end else if (tmr_done) begin
            ready_hold_reg <= 1'b1;
        end else if (start_bit || !device_pick_i) begin
            ready_hold_reg <= 1'b0;
        end
    end

    // Query frame loaded after address bits
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            qry_active_reg <= 1'b0;
            qry_sr_reg <= 10'h0;
        end else if (state_reg != ees_pkg::EES_ST_SHIFT || !device_pick_i) begin
            qry_active_reg <= 1'b0;
        end else if (!qry_active_reg && is_short && pre_frame_reg && op_s == `EES_OP_READ) begin
            qry_active_reg <= 1'b1;
            qry_sr_reg <= {`EES_QRY_DUMMY, boundary_reg, flag_reg};
        end else if (qry_active_reg && c_rise) begin
            qry_sr_reg <= {qry_sr_reg[8:0], 1'b0};
        end
    end

    // Busy low, ready high while selected
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            output_bit_line_o <= 1'b0;
            output_bit_line_oe_o <= 1'b0;
        end else if (state_reg == ees_pkg::EES_ST_BUSY && device_pick_i) begin
            output_bit_line_o <= 1'b0;
            output_bit_line_oe_o <= 1'b1;
        end else if (ready_hold_reg && device_pick_i) begin
            output_bit_line_o <= 1'b1;
            output_bit_line_oe_o <= 1'b1;
        end else if (qry_active_reg) begin
            output_bit_line_o <= qry_sr_reg[`EES_QRY_LEN - 1];
            output_bit_line_oe_o <= 1'b1;
        end else begin
            output_bit_line_o <= 1'b0;
            output_bit_line_oe_o <= 1'b0;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // Cycles spent in the busy state
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_cyc_reg <= 32'h0;
        end else if (state_reg == ees_pkg::EES_ST_BUSY) begin
            busy_cyc_reg <= busy_cyc_reg + 32'h1;
        end else begin
            busy_cyc_reg <= 32'h0;
        end
    end

    AST_FILL_NEEDS_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        decide && kind == ees_pkg::EES_K_FILL && flag_reg == `EES_FLAG_ACTIVE |=> state_reg == ees_pkg::EES_ST_IDLE)
        else $error("fill ran with boundary not cleared");

    AST_FILL_ALL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        start_prog && kind == ees_pkg::EES_K_FILL |=> mem[0] == $past(data_l) && mem[255] == $past(data_l))
        else $error("fill did not reach every word");

    AST_BUSY_LOW: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        state_reg == ees_pkg::EES_ST_BUSY && device_pick_i |=> output_bit_line_oe_o && !output_bit_line_o)
        else $error("busy not shown low");

    AST_IGNORE_BUSY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        state_reg == ees_pkg::EES_ST_BUSY ##1 state_reg == ees_pkg::EES_ST_BUSY |-> $stable(cnt_reg) && $stable(sr_reg))
        else $error("input taken while busy");

    AST_READY_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        tmr_done ##1 device_pick_i |=> output_bit_line_oe_o && output_bit_line_o)
        else $error("ready not shown high");

    AST_SELF_TIMED: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        tmr_done |-> busy_cyc_reg == 32'(PROG_CYCLES))
        else $error("programming time wrong");

    AST_PROTECT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        decide && kind == ees_pkg::EES_K_WRITE && protected_hit |=> state_reg == ees_pkg::EES_ST_IDLE)
        else $error("write into protected area");

    AST_FREEZE_FIXED: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        freeze_reg |=> freeze_reg && $stable(boundary_reg) && $stable(flag_reg))
        else $error("frozen boundary changed");

    AST_QUERY_DUMMY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(qry_active_reg) && device_pick_i && state_reg == ees_pkg::EES_ST_SHIFT |=> output_bit_line_oe_o && !output_bit_line_o)
        else $error("query dummy bit missing");

    AST_UNLOCK_FLAG: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        decide && kind == ees_pkg::EES_K_GUNLK |=> $stable(flag_reg) && $stable(boundary_reg))
        else $error("guard unlock changed flag");

    AST_PULSE_COUNT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        decide && !is_long && !is_short |=> state_reg == ees_pkg::EES_ST_IDLE && $stable(boundary_reg))
        else $error("miscounted frame executed");

    AST_POWERUP_LOCK: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        decide && !prog_en_reg && kind == ees_pkg::EES_K_WRITE |=> state_reg == ees_pkg::EES_ST_IDLE)
        else $error("write executed while locked");

    AST_TIMER_IN_BUSY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        tmr_busy |-> state_reg == ees_pkg::EES_ST_BUSY)
        else $error("timer running outside busy state");

endmodule

//--- sim/ees_master_model.sv
`timescale 1ns/1ns
// Bus master model on the serial pins
module ees_master_model (
    input wire logic clk_i,  // System clock
    input wire logic dout_i, // Device data out
    output logic pick_o,     // Chip select
    output logic sclk_o,     // Serial clock
    output logic din_o,      // Serial data in
    output logic permit_o,   // Write permission
    output logic guard_o     // Boundary access
);
    // Idle levels, clock still outside frames
    initial begin
        pick_o = 1'b0;
        sclk_o = 1'b0;
        din_o = 1'b0;
        permit_o = 1'b1;
        guard_o = 1'b0;
    end
    // One pulse, 2 clk high, 3 clk low
    // data set before the rising edge
    task automatic pulse(input logic d);
        @(posedge clk_i);
        din_o <= d;
        @(posedge clk_i);
        sclk_o <= 1'b1;
        repeat (2) @(posedge clk_i);
        sclk_o <= 1'b0;
        @(posedge clk_i);
    endtask
    // Whole frame, MSB first; data line flipped once released
    // select dropped before next edge
    // guard pin and permit held for frame
    task automatic send(input logic [27:0] bits, input int n, input logic g);
        @(posedge clk_i);
        guard_o <= g;
        pick_o <= 1'b1;
        for (int i = n - 1; i >= 0; i--) begin
            pulse(bits[i]);
        end
        pick_o <= 1'b0;
        din_o <= ~din_o;
    endtask
    // Boundary read, ten bits back
    // guard pin high for whole query
    task automatic query(output logic [9:0] q);
        @(posedge clk_i);
        guard_o <= 1'b1;
        pick_o <= 1'b1;
        for (int i = 10; i >= 0; i--) begin
            pulse(i >= 9);
        end
        for (int i = 9; i >= 0; i--) begin
            #1 q[i] = dout_i;
            if (i > 0) begin
                pulse(1'b0);
            end
        end
        @(posedge clk_i);
        pick_o <= 1'b0;
        guard_o <= 1'b0;
    endtask
    // Status poll, bounded wait for ready
    // poll after frame end
    task automatic poll(output int busy_n, output logic rdy);
        busy_n = 0;
        rdy = 1'b0;
        @(posedge clk_i);
        pick_o <= 1'b1;
        repeat (2) @(posedge clk_i);
        for (int i = 0; i < 300 && rdy !== 1'b1; i++) begin
            @(posedge clk_i);
            #1;
            if (dout_i === 1'b1) rdy = 1'b1;
            else busy_n++;
        end
        repeat (3) @(posedge clk_i);
        #1 rdy = rdy & dout_i;
        @(posedge clk_i);
        pick_o <= 1'b0;
    endtask
endmodule

//--- sim/test_serial_eeprom_fill_and_protect.sv
`timescale 1ns/1ns
module test_serial_eeprom_fill_and_protect;
    localparam int PC = 80;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] peek_addr_i = 8'h00;
    logic pick, sclk, din, permit, guard, dout, dout_oe;
    logic [15:0] peek_data;
    int bad_count = 0;
    int tests_run = 0;
    int fb;
    logic fr;

    // ----------------------------------------
    // Clock, device and master
    // ----------------------------------------
    always #5 clk_i = ~clk_i;
    ees_core #(.PROG_CYCLES(PC)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .device_pick_i(pick),
        .shift_timing_i(sclk), .input_bit_line_i(din), .program_permit_i(permit),
        .guard_access_i(guard), .peek_addr_i(peek_addr_i), .output_bit_line_o(dout),
        .output_bit_line_oe_o(dout_oe), .peek_data_o(peek_data));
    ees_master_model mst_u (.clk_i(clk_i), .dout_i(dout), .pick_o(pick), .sclk_o(sclk),
        .din_o(din), .permit_o(permit), .guard_o(guard));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic results;
        $display("Checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic lng(input logic [1:0] op, input logic [7:0] a, input logic [15:0] d, input bit extra);
        mst_u.send(extra ? {1'b1, op, a, d, 1'b0} : {1'b0, 1'b1, op, a, d}, extra ? 28 : 27, 1'b0);
    endtask
    task automatic sht(input logic [1:0] op, input logic [7:0] a, input logic g);
        mst_u.send({17'h0, 1'b1, op, a}, 11, g);
    endtask
    // Poll to ready; fresh means busy must be seen
    task automatic ready(input bit fresh);
        int b;
        logic r;
        mst_u.poll(b, r);
        chk("ready", {15'h0, r}, 16'h1);
        chk("busy", {15'h0, b <= PC + 1 && (b > 0 || !fresh)}, 16'h1);
        if (r !== 1'b1) results();
    endtask
    task automatic pk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk_i);
        peek_addr_i <= a;
        repeat (2) @(posedge clk_i);
        #1 chk("peek", peek_data, exp);
    endtask
    task automatic qry(input logic [9:0] exp);
        logic [9:0] q;
        mst_u.query(q);
        chk("query", {6'h0, q}, {6'h0, exp});
        repeat (2) @(posedge clk_i);
        #1 chk("query oe", {15'h0, dout_oe}, 16'h0);
    endtask
    task automatic idle;
        repeat (PC + 10) @(posedge clk_i);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        qry(10'h1FF);
        lng(2'h1, 8'h10, 16'h1111, 1'b0);
        idle();
        sht(2'h0, 8'hC0, 1'b0);
        lng(2'h0, 8'h40, 16'hA5A5, 1'b0);
        ready(1'b1);
        pk(8'h10, 16'hA5A5);
        pk(8'hFF, 16'hA5A5);
        lng(2'h1, 8'h10, 16'h1234, 1'b1);
        idle();
        pk(8'h10, 16'hA5A5);
        lng(2'h1, 8'h10, 16'h1234, 1'b0);
        sht(2'h0, 8'h00, 1'b0);
        ready(1'b0);
        pk(8'h10, 16'h1234);
        lng(2'h1, 8'h7F, 16'hBEEF, 1'b0);
        ready(1'b1);
        pk(8'h7F, 16'hBEEF);
        sht(2'h0, 8'hC0, 1'b1);
        sht(2'h1, 8'h80, 1'b1);
        ready(1'b1);
        qry(10'h100);
        sht(2'h0, 8'hC0, 1'b1);
        qry(10'h100);
        lng(2'h1, 8'h80, 16'h0F0F, 1'b0);
        idle();
        pk(8'h80, 16'hA5A5);
        lng(2'h0, 8'h40, 16'h5A5A, 1'b0);
        idle();
        pk(8'h00, 16'hA5A5);
        sht(2'h1, 8'h20, 1'b1);
        idle();
        qry(10'h100);
        sht(2'h0, 8'hC0, 1'b1);
        sht(2'h3, 8'hFF, 1'b1);
        ready(1'b1);
        qry(10'h1FF);
        sht(2'h0, 8'h00, 1'b0);
        lng(2'h0, 8'h40, 16'h5A5A, 1'b0);
        idle();
        pk(8'h00, 16'hA5A5);
        sht(2'h0, 8'hC0, 1'b0);
        sht(2'h0, 8'hC0, 1'b1);
        sht(2'h0, 8'h00, 1'b1);
        idle();
        sht(2'h0, 8'hC0, 1'b1);
        sht(2'h1, 8'h40, 1'b1);
        mst_u.poll(fb, fr);
        chk("frozen status", {15'h0, fr}, 16'h0);
        qry(10'h1FF);
        sht(2'h0, 8'h00, 1'b0);
        @(posedge clk_i);
        mst_u.permit_o <= 1'b0;
        sht(2'h0, 8'hC0, 1'b0);
        @(posedge clk_i);
        mst_u.permit_o <= 1'b1;
        lng(2'h1, 8'h10, 16'h5555, 1'b0);
        idle();
        pk(8'h10, 16'h1234);
        results();
    end
endmodule
